// ### logic/lane_rx_map.svh
`ifndef LANE_RX_MAP_SVH
`define LANE_RX_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define LRX_ADDR_W      4
`define LRX_OFF_STATUS  4'h0
`define LRX_OFF_MASK    4'h4
`define LRX_OFF_LANEDIS 4'h8
`define LRX_OFF_STATE   4'hc

// ****************************************
// event bits of status and mask
// ****************************************
`define LRX_EV_W        5
`define LRX_EV_SYNC     0
`define LRX_EV_LPDT     1
`define LRX_EV_ULPS     2
`define LRX_EV_TRIG     3
`define LRX_EV_END      4

// ****************************************
// line states as {p, n}
// ****************************************
`define LRX_LP_00       2'h0
`define LRX_LP_01       2'h1
`define LRX_LP_10       2'h2
`define LRX_LP_11       2'h3

// ****************************************
// patterns, first bit received in bit 0
// ****************************************
`define LRX_SYNC_BYTE   8'hb8
`define LRX_SKEW_BYTE   8'hff
`define LRX_CMD_LPDT    8'h87
`define LRX_CMD_ULPS    8'h78
`define LRX_CMD_RESET   8'h46
`define LRX_CMD_UNK3    8'hba
`define LRX_CMD_UNK4    8'h84
`define LRX_CMD_UNK5    8'h05
`define LRX_TRIG_RESET  4'h1
`define LRX_TRIG_UNK3   4'h2
`define LRX_TRIG_UNK4   4'h4
`define LRX_TRIG_UNK5   4'h8
`define LRX_TRIG_NONE   4'h0

// ****************************************
// bit and byte clock counting
// ****************************************
`define LRX_BIT_LAST    3'h7
`define LRX_DIV_HALF    3'h4
`define LRX_BIT_STEP    3'h1

`endif

// ### logic/lane_rx_pkg.sv
`default_nettype none

package lane_rx_pkg;

  typedef struct packed {
    logic lp_p;
    logic lp_n;
    logic hs_bit;
  } lane_pin_t;

  typedef struct packed {
    logic [7:0] hs_data;
    logic       hs_valid;
    logic       hs_active;
    logic       hs_sync;
    logic       skewcal;
    logic       esc_clk;
    logic       lpdt;
    logic       ulps;
    logic [3:0] trig;
    logic [7:0] esc_data;
    logic       esc_valid;
  } lane_out_t;

  typedef enum logic [3:0] {
    L_STOP,
    L_HS_RQ,
    L_HS_HUNT,
    L_HS_DATA,
    L_SKEW,
    L_ESC_RQ,
    L_ESC_BR,
    L_ESC_ACK,
    L_ESC_CMD,
    L_LPDT,
    L_ULPS,
    L_TRIG,
    L_WAIT
  } lane_fsm_t;

  typedef struct packed {
    lane_fsm_t  fsm;
    logic [1:0] lp_prev;
    logic [7:0] sr;
    logic [2:0] bits;
    logic [7:0] hold;
    logic       pend;
    logic       sync_pend;
    logic       ones;
  } lane_ctx_t;

endpackage

`default_nettype wire

// ### logic/lane_rx_port.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lane_rx_map.svh"

// Behaviour
// - byte clock is the received DDR clock divided by four (eight DDR edges); HS outputs follow it
// - byte clock runs only while the clock lane is in high-speed mode
// - HS byte is eight bits, bit 0 received first, updated at byte clock rise
// - no ready input on the HS path; delivery never pauses
// - HS active flag stays high while a burst is being received
// - sync flag pulses one byte clock cycle as active first rises
// - skew flag high during a deskew burst, only in high-rate builds
// - force input re-initializes the lane; release after stop for T_INIT
// - escape clock derived from the two low-power line levels, aperiodic
// - LPDT flag high from entry until stop; bytes shown with escape valid
// - ULPS flag raised on entry, held until stop
// - triggers one-hot: reset 0001, unknown-3 0010, unknown-4 0100, unknown-5 1000
// - trigger bit stays set until stop
// - escape byte eight bits, bit 0 first, moves at escape clock rise
// - escape path has no ready; consumer takes every valid byte
module lane_rx_port #(
  parameter int unsigned NUM_LANES  = 2,
  parameter bit          SKEWCAL_EN = 1'b1
) (
  input  wire logic                                     clk_i,
  input  wire logic                                     nrst_i,
  input  wire logic                                     ce_i,
  input  wire logic                                     hs_clk_i,
  input  wire logic                                     clk_lane_hs_i,
  input  wire lane_rx_pkg::lane_pin_t [NUM_LANES-1:0]   lane_pin_i,
  input  wire logic [NUM_LANES-1:0]                     force_rx_i,
  input  wire logic [`LRX_ADDR_W-1:0]                   addr_i,
  input  wire logic [31:0]                              wdata_i,
  input  wire logic                                     we_i,
  input  wire logic                                     re_i,
  output var  logic [31:0]                              rdata_o,
  output var  logic                                     irq_o,
  output var  logic                                     byte_clk_o,
  output var  lane_rx_pkg::lane_out_t [NUM_LANES-1:0]   lane_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    lane_rx_pkg::lane_pin_t [NUM_LANES-1:0]  pin1;
    lane_rx_pkg::lane_pin_t [NUM_LANES-1:0]  pin2;
    logic [NUM_LANES-1:0]                    force1;
    logic [NUM_LANES-1:0]                    force2;
    logic [NUM_LANES-1:0]                    lane_dis;
    logic [1:0]                              clk1;
    logic [1:0]                              clk2;
    logic                                    clk_prev;
    logic [2:0]                              div;
    logic                                    byte_clk;
    lane_rx_pkg::lane_ctx_t [NUM_LANES-1:0]  ctx;
    lane_rx_pkg::lane_out_t [NUM_LANES-1:0]  outs;
    logic [`LRX_EV_W-1:0]                    status;
    logic [`LRX_EV_W-1:0]                    mask;
    logic                                    irq;
    logic [31:0]                             rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b);
    shift_in = {b, sr[7:1]};
  endfunction

  function automatic logic [3:0] trig_code(input logic [7:0] cmd);
    case (cmd)
      `LRX_CMD_RESET: trig_code = `LRX_TRIG_RESET;
      `LRX_CMD_UNK3:  trig_code = `LRX_TRIG_UNK3;
      `LRX_CMD_UNK4:  trig_code = `LRX_TRIG_UNK4;
      `LRX_CMD_UNK5:  trig_code = `LRX_TRIG_UNK5;
      default:        trig_code = `LRX_TRIG_NONE;
    endcase
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    lane_rx_pkg::lane_ctx_t  c;
    lane_rx_pkg::lane_out_t  o;
    logic [1:0]              lp;
    logic [7:0]              nsr;
    logic                    ddr_edge;
    logic                    wrap;
    logic                    mark;
    logic [`LRX_EV_W-1:0]    ev;
    logic [`LRX_EV_W-1:0]    clr;
    logic [NUM_LANES-1:0]    act_v;
    logic [NUM_LANES-1:0]    ulps_v;
    c        = '0;
    o        = '0;
    lp       = `LRX_LP_11;
    nsr      = '0;
    ddr_edge = 1'b0;
    wrap     = 1'b0;
    mark     = 1'b0;
    ev       = '0;
    clr      = '0;
    act_v    = '0;
    ulps_v   = '0;
    next_st  = st;

    // pin synchronisers
    next_st.pin1   = lane_pin_i;
    next_st.pin2   = st.pin1;
    next_st.force1 = force_rx_i;
    next_st.force2 = st.force1;
    next_st.clk1   = {clk_lane_hs_i, hs_clk_i};
    next_st.clk2   = st.clk1;
    next_st.clk_prev = st.clk2[0];

    // byte clock only advances on DDR edges in HS mode
    ddr_edge = st.clk2[1] && (st.clk2[0] != st.clk_prev);
    wrap     = ddr_edge && (st.div == `LRX_BIT_LAST);
    if (ddr_edge)
    begin
      next_st.div      = st.div + `LRX_BIT_STEP;
      next_st.byte_clk = (next_st.div < `LRX_DIV_HALF);
    end

    for (int i = 0; i < NUM_LANES; i++)
    begin
      c  = st.ctx[i];
      o  = st.outs[i];
      lp = {st.pin2[i].lp_p, st.pin2[i].lp_n};
      o.esc_clk = lp[1] ^ lp[0];

      // present at byte clock rise, one byte clock per item
      if (wrap)
      begin
        o.hs_data   = c.hold;
        o.hs_valid  = c.pend;
        o.hs_sync   = c.sync_pend;
        o.hs_active = (c.fsm == lane_rx_pkg::L_HS_DATA);
        c.pend      = 1'b0;
        c.sync_pend = 1'b0;
      end

      mark = (c.lp_prev == `LRX_LP_00) && ((lp == `LRX_LP_10) || (lp == `LRX_LP_01));

      case (c.fsm)
        lane_rx_pkg::L_STOP:
        begin
          if (lp == `LRX_LP_01)
            c.fsm = lane_rx_pkg::L_HS_RQ;
          else if (lp == `LRX_LP_10)
            c.fsm = lane_rx_pkg::L_ESC_RQ;
        end
        lane_rx_pkg::L_HS_RQ:
        begin
          if (lp == `LRX_LP_00)
          begin
            c.fsm  = lane_rx_pkg::L_HS_HUNT;
            c.sr   = '0;
            c.ones = 1'b0;
          end
          else if (lp == `LRX_LP_10)
            c.fsm = lane_rx_pkg::L_WAIT;
        end
        lane_rx_pkg::L_HS_HUNT:
        begin
          if (ddr_edge)
          begin
            nsr  = shift_in(c.sr, st.pin2[i].hs_bit);
            c.sr = nsr;
            if (nsr == `LRX_SYNC_BYTE)
            begin
              c.fsm       = lane_rx_pkg::L_HS_DATA;
              c.bits      = '0;
              c.sync_pend = 1'b1;
              ev[`LRX_EV_SYNC] = 1'b1;
            end
            else if (SKEWCAL_EN && (nsr == `LRX_SKEW_BYTE))
            begin
              c.sr = '0;
              if (c.ones)
              begin
                c.fsm     = lane_rx_pkg::L_SKEW;
                o.skewcal = 1'b1;
              end
              c.ones = 1'b1;
            end
            // a zero bit breaks a run of ones
            else if (!st.pin2[i].hs_bit)
              c.ones = 1'b0;
          end
        end
        lane_rx_pkg::L_HS_DATA:
        begin
          if (ddr_edge)
          begin
            nsr    = shift_in(c.sr, st.pin2[i].hs_bit);
            c.sr   = nsr;
            c.bits = c.bits + `LRX_BIT_STEP;
            if (c.bits == '0)
            begin
              c.hold = nsr;
              c.pend = 1'b1;
            end
          end
        end
        lane_rx_pkg::L_ESC_RQ:
        begin
          if (lp == `LRX_LP_00)
            c.fsm = lane_rx_pkg::L_ESC_BR;
          else if (lp == `LRX_LP_01)
            c.fsm = lane_rx_pkg::L_WAIT;
        end
        lane_rx_pkg::L_ESC_BR:
        begin
          if (lp == `LRX_LP_01)
            c.fsm = lane_rx_pkg::L_ESC_ACK;
          else if (lp == `LRX_LP_10)
            c.fsm = lane_rx_pkg::L_WAIT;
        end
        lane_rx_pkg::L_ESC_ACK:
        begin
          if (lp == `LRX_LP_00)
          begin
            c.fsm  = lane_rx_pkg::L_ESC_CMD;
            c.bits = '0;
            c.sr   = '0;
          end
          else if (lp == `LRX_LP_10)
            c.fsm = lane_rx_pkg::L_WAIT;
        end
        lane_rx_pkg::L_ESC_CMD:
        begin
          if (mark)
          begin
            nsr    = shift_in(c.sr, lp[1]);
            c.sr   = nsr;
            c.bits = c.bits + `LRX_BIT_STEP;
            if (c.bits == '0)
            begin
              if (nsr == `LRX_CMD_LPDT)
              begin
                c.fsm  = lane_rx_pkg::L_LPDT;
                o.lpdt = 1'b1;
              end
              else if (nsr == `LRX_CMD_ULPS)
              begin
                c.fsm  = lane_rx_pkg::L_ULPS;
                o.ulps = 1'b1;
                ev[`LRX_EV_ULPS] = 1'b1;
              end
              else if (trig_code(nsr) != `LRX_TRIG_NONE)
              begin
                c.fsm  = lane_rx_pkg::L_TRIG;
                o.trig = trig_code(nsr);
                ev[`LRX_EV_TRIG] = 1'b1;
              end
              else
                c.fsm = lane_rx_pkg::L_WAIT;
            end
          end
        end
        lane_rx_pkg::L_LPDT:
        begin
          if (mark)
          begin
            nsr         = shift_in(c.sr, lp[1]);
            c.sr        = nsr;
            c.bits      = c.bits + `LRX_BIT_STEP;
            o.esc_valid = 1'b0;
            if (c.bits == '0)
            begin
              o.esc_data  = nsr;
              o.esc_valid = 1'b1;
              ev[`LRX_EV_LPDT] = 1'b1;
            end
          end
        end
        lane_rx_pkg::L_SKEW,
        lane_rx_pkg::L_ULPS,
        lane_rx_pkg::L_TRIG,
        lane_rx_pkg::L_WAIT:
        begin
          c.fsm = c.fsm;
        end
        default:
          c.fsm = lane_rx_pkg::L_STOP;
      endcase

      // stop state ends every mode and drops held flags
      if ((lp == `LRX_LP_11) && (c.fsm != lane_rx_pkg::L_STOP))
      begin
        if (c.fsm == lane_rx_pkg::L_HS_DATA)
          ev[`LRX_EV_END] = 1'b1;
        c.fsm       = lane_rx_pkg::L_STOP;
        c.pend      = 1'b0;
        c.sync_pend = 1'b0;
        o.hs_valid  = 1'b0;
        o.hs_active = 1'b0;
        o.hs_sync   = 1'b0;
        o.skewcal   = 1'b0;
        o.lpdt      = 1'b0;
        o.ulps      = 1'b0;
        o.trig      = `LRX_TRIG_NONE;
        o.esc_valid = 1'b0;
      end

      // forced or disabled lane held in its reset state
      if (st.force2[i] || st.lane_dis[i])
      begin
        c = '0;
        o = '0;
      end

      c.lp_prev         = lp;
      next_st.ctx[i]    = c;
      next_st.outs[i]   = o;
      act_v[i]          = st.outs[i].hs_active;
      ulps_v[i]         = st.outs[i].ulps;
    end

    // ****************************************
    // register port
    // ****************************************
    if (we_i && (addr_i == `LRX_OFF_STATUS))
      clr = wdata_i[`LRX_EV_W-1:0];
    next_st.status = (st.status & ~clr) | ev;
    if (we_i && (addr_i == `LRX_OFF_MASK))
      next_st.mask = wdata_i[`LRX_EV_W-1:0];
    if (we_i && (addr_i == `LRX_OFF_LANEDIS))
      next_st.lane_dis = wdata_i[NUM_LANES-1:0];
    next_st.irq = |(next_st.status & next_st.mask);

    next_st.rdata = '0;
    if (re_i)
    begin
      case (addr_i)
        `LRX_OFF_STATUS:  next_st.rdata = 32'(st.status);
        `LRX_OFF_MASK:    next_st.rdata = 32'(st.mask);
        `LRX_OFF_LANEDIS: next_st.rdata = 32'(st.lane_dis);
        `LRX_OFF_STATE:   next_st.rdata = {16'(ulps_v), 16'(act_v)};
        default:          next_st.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st <= '0;
    else if (ce_i)
      st <= next_st;
  end

  assign rdata_o    = st.rdata;
  assign irq_o      = st.irq;
  assign byte_clk_o = st.byte_clk;
  assign lane_o     = st.outs;

endmodule

`default_nettype wire

// ### tb/lane_consumer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// protocol-side byte consumer
// ****************************************
module lane_consumer (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   byte_clk_i,
  input  wire lane_rx_pkg::lane_out_t lane_i,
  output logic                        hs_stb_o,
  output logic [7:0]                  hs_byte_o,
  output logic                        esc_stb_o,
  output logic [7:0]                  esc_byte_o
);
  logic byte_clk_q;
  logic esc_take_q;

  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      byte_clk_q <= 1'b0;
      esc_take_q <= 1'b0;
    end
    else
    begin
      byte_clk_q <= byte_clk_i;
      esc_take_q <= lane_i.esc_clk & lane_i.esc_valid;
    end

  // no way to stall the lane: every flagged byte is taken
  assign hs_stb_o   = byte_clk_i & ~byte_clk_q & lane_i.hs_valid;
  assign hs_byte_o  = lane_i.hs_data;
  assign esc_stb_o  = lane_i.esc_clk & lane_i.esc_valid & ~esc_take_q;
  assign esc_byte_o = lane_i.esc_data;
endmodule
`default_nettype wire

// ### tb/lane_rx_port_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// lane port checker
// ****************************************
module lane_rx_port_props #(
  parameter int unsigned NUM_LANES  = 2,
  parameter bit          SKEWCAL_EN = 1'b1
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   nrst_i,
  input  wire logic                                   clk_lane_hs_i,
  input  wire lane_rx_pkg::lane_pin_t [NUM_LANES-1:0] lane_pin_i,
  input  wire logic [NUM_LANES-1:0]                   force_rx_i,
  input  wire logic                                   byte_clk_o,
  input  wire lane_rx_pkg::lane_out_t [NUM_LANES-1:0] lane_o
);
  logic [5:0] stop_hist;

  // recent stop or force seen on lane 0
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      stop_hist <= 6'h00;
    else
      stop_hist <= {stop_hist[4:0],
                    (lane_pin_i[0].lp_p & lane_pin_i[0].lp_n) | force_rx_i[0]};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_sync_start;
    $rose(lane_o[0].hs_sync) |-> $rose(byte_clk_o) && $rose(lane_o[0].hs_active);
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync pulse not at burst start");
  property p_sync_one;
    $rose(byte_clk_o) && !$rose(lane_o[0].hs_sync) |-> !lane_o[0].hs_sync;
  endproperty
  a_sync_one: assert property (p_sync_one)
    else $error("sync pulse longer than one byte clock");
  property p_valid_at_wrap;
    $rose(lane_o[0].hs_valid) |-> $rose(byte_clk_o);
  endproperty
  a_valid_at_wrap: assert property (p_valid_at_wrap)
    else $error("hs valid rose off the byte clock");
  property p_byteclk_frozen;
    !clk_lane_hs_i [*4] |=> $stable(byte_clk_o);
  endproperty
  a_byteclk_frozen: assert property (p_byteclk_frozen)
    else $error("byte clock runs outside hs mode");
  property p_active_until_stop;
    $fell(lane_o[0].hs_active) |-> |stop_hist;
  endproperty
  a_active_until_stop: assert property (p_active_until_stop)
    else $error("hs active dropped without stop");
  property p_lpdt_until_stop;
    $fell(lane_o[0].lpdt) |-> |stop_hist;
  endproperty
  a_lpdt_until_stop: assert property (p_lpdt_until_stop)
    else $error("lpdt dropped without stop");
  property p_ulps_until_stop;
    $fell(lane_o[0].ulps) |-> |stop_hist;
  endproperty
  a_ulps_until_stop: assert property (p_ulps_until_stop)
    else $error("ulps dropped without stop");
  property p_trig_until_stop;
    $changed(lane_o[0].trig) && |$past(lane_o[0].trig) |-> |stop_hist;
  endproperty
  a_trig_until_stop: assert property (p_trig_until_stop)
    else $error("trigger changed without stop");
  property p_trig_onehot;
    $onehot0(lane_o[0].trig);
  endproperty
  a_trig_onehot: assert property (p_trig_onehot)
    else $error("trigger not one-hot");
  property p_skew_hunt;
    $rose(lane_o[0].skewcal) |-> SKEWCAL_EN && !lane_o[0].hs_active;
  endproperty
  a_skew_hunt: assert property (p_skew_hunt)
    else $error("skew flag outside deskew hunt");

  c_sync: cover property ($rose(lane_o[0].hs_sync));
  c_skew: cover property ($rose(lane_o[0].skewcal));
  c_lpdt: cover property ($rose(lane_o[0].lpdt));
endmodule

bind lane_rx_port lane_rx_port_props #(.NUM_LANES(NUM_LANES), .SKEWCAL_EN(SKEWCAL_EN)) i_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .clk_lane_hs_i(clk_lane_hs_i), .lane_pin_i(lane_pin_i),
  .force_rx_i(force_rx_i), .byte_clk_o(byte_clk_o), .lane_o(lane_o));
`default_nettype wire

// ### tb/lane_rx_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lane_rx_map.svh"
// ****************************************
// lane receive port bench
// ****************************************
module lane_rx_port_tb;
  logic                         clk_i = 1'b0;
  logic                         nrst_i = 1'b0;
  logic                         hs_clk_i = 1'b0;
  logic                         clk_lane_hs_i = 1'b0;
  lane_rx_pkg::lane_pin_t [1:0] lane_pin_i = 6'h36;
  logic [1:0]                   force_rx_i = 2'h0;
  logic [3:0]                   addr_i = 4'h0;
  logic [31:0]                  wdata_i = 32'h0;
  logic                         we_i = 1'b0;
  logic                         re_i = 1'b0;
  logic [31:0]                  rdata_o;
  logic                         irq_o;
  logic                         byte_clk_o;
  lane_rx_pkg::lane_out_t [1:0] lane_o;
  logic                         hs_stb;
  logic                         esc_stb;
  logic [7:0]                   hs_byte;
  logic [7:0]                   esc_byte;
  logic [7:0]                   sent_q[$];
  logic [7:0]                   got_q[$];
  logic [7:0]                   esc_q[$];
  logic [7:0]                   cmds[4] = '{`LRX_CMD_RESET, `LRX_CMD_UNK3, `LRX_CMD_UNK4,
                                            `LRX_CMD_UNK5};
  int                           fails = 0;
  int                           samples_checked = 0;

  always #20 clk_i = ~clk_i;

  lane_rx_port i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .hs_clk_i(hs_clk_i),
    .clk_lane_hs_i(clk_lane_hs_i), .lane_pin_i(lane_pin_i), .force_rx_i(force_rx_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .byte_clk_o(byte_clk_o), .lane_o(lane_o));
  lane_consumer i_consumer (.clk_i(clk_i), .nrst_i(nrst_i), .byte_clk_i(byte_clk_o),
    .lane_i(lane_o[0]), .hs_stb_o(hs_stb), .hs_byte_o(hs_byte), .esc_stb_o(esc_stb),
    .esc_byte_o(esc_byte));

  always @(posedge clk_i)
  begin
    if (hs_stb) got_q.push_back(hs_byte);
    if (esc_stb) esc_q.push_back(esc_byte);
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic set_lp(input logic [1:0] lp);
    {lane_pin_i[0].lp_p, lane_pin_i[0].lp_n} <= lp;
    tick(6);
  endtask
  task automatic hs_tx(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      lane_pin_i[0].hs_bit <= b[i];
      hs_clk_i <= ~hs_clk_i;
      tick(3);
    end
  endtask
  task automatic esc_tx(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      set_lp(b[i] ? 2'h2 : 2'h1);
      set_lp(2'h0);
    end
  endtask
  task automatic esc_enter(input logic [7:0] cmd);
    set_lp(2'h2);
    set_lp(2'h0);
    set_lp(2'h1);
    set_lp(2'h0);
    esc_tx(cmd);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    tick(1);
    we_i <= 1'b0;
    tick(1);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    re_i <= 1'b1;
    addr_i <= a;
    tick(1);
    re_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
    tick(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    tick(30000);
    fails++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] d;
    logic [7:0]  b;
    void'($urandom(32'hae85c2bc));
    tick(10);
    nrst_i <= 1'b1;
    tick(2);
    // hs burst, random payload ending in an all-ones byte
    clk_lane_hs_i <= 1'b1;
    set_lp(2'h1);
    set_lp(2'h0);
    hs_tx(`LRX_SYNC_BYTE);
    for (int i = 0; i < 6; i++)
    begin
      b = (i == 5) ? 8'hff : 8'($urandom);
      sent_q.push_back(b);
      hs_tx(b);
    end
    hs_tx(8'h00);
    hs_tx(8'h00);
    chk("hs_active", 32'h1, {31'h0, lane_o[0].hs_active});
    set_lp(2'h3);
    clk_lane_hs_i <= 1'b0;
    chk("hs_active end", 32'h0, {31'h0, lane_o[0].hs_active});
    chk("hs count", 32'h1, {31'h0, got_q.size() >= 6});
    foreach (sent_q[i])
      chk("hs byte", {24'h0, sent_q[i]}, {24'h0, got_q[i]});
    // status, mask, interrupt, unmapped place
    reg_rd(4'h0, d);
    chk("status", 32'h11, d);
    reg_wr(4'h4, 32'h1);
    chk("irq set", 32'h1, {31'h0, irq_o});
    reg_wr(4'h0, 32'h1);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    reg_rd(4'h0, d);
    chk("status w1c", 32'h10, d);
    reg_rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    reg_wr(4'h8, 32'h2);
    reg_rd(4'h8, d);
    chk("lane disable", 32'h2, d);
    reg_wr(4'h8, 32'h0);
    // deskew burst
    clk_lane_hs_i <= 1'b1;
    set_lp(2'h1);
    set_lp(2'h0);
    hs_tx(`LRX_SKEW_BYTE);
    hs_tx(`LRX_SKEW_BYTE);
    tick(6);
    chk("skewcal", 32'h1, {31'h0, lane_o[0].skewcal});
    set_lp(2'h3);
    clk_lane_hs_i <= 1'b0;
    chk("skewcal end", 32'h0, {31'h0, lane_o[0].skewcal});
    // low-power data
    sent_q.delete();
    esc_enter(`LRX_CMD_LPDT);
    chk("lpdt", 32'h1, {31'h0, lane_o[0].lpdt});
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      sent_q.push_back(b);
      esc_tx(b);
    end
    set_lp(2'h3);
    chk("lpdt end", 32'h0, {31'h0, lane_o[0].lpdt});
    foreach (sent_q[i])
      chk("esc byte", {24'h0, sent_q[i]}, {24'h0, esc_q[i]});
    // ultra-low-power entry and exit
    esc_enter(`LRX_CMD_ULPS);
    chk("ulps", 32'h1, {31'h0, lane_o[0].ulps});
    reg_rd(4'hc, d);
    chk("state ulps", 32'h10000, d);
    set_lp(2'h2);
    set_lp(2'h3);
    chk("ulps end", 32'h0, {31'h0, lane_o[0].ulps});
    // every trigger code
    for (int i = 0; i < 4; i++)
    begin
      esc_enter(cmds[i]);
      tick(20);
      chk("trigger", {28'h0, 4'h1 << i}, {28'h0, lane_o[0].trig});
      set_lp(2'h3);
      chk("trigger end", 32'h0, {28'h0, lane_o[0].trig});
    end
    // force raised only while stopped; forced lane ignores escape entry
    force_rx_i[0] <= 1'b1;
    tick(6);
    esc_enter(`LRX_CMD_LPDT);
    chk("forced lpdt", 32'h0, {31'h0, lane_o[0].lpdt});
    set_lp(2'h3);
    tick(10);
    force_rx_i[0] <= 1'b0;
    tick(6);
    esc_enter(`LRX_CMD_LPDT);
    chk("lpdt after force", 32'h1, {31'h0, lane_o[0].lpdt});
    set_lp(2'h3);
    chk("idle lane", 32'h0, {4'h0, lane_o[1]});
    end_of_test();
  end
endmodule
`default_nettype wire
